// ---- keypad_gpio.sv ----
// Keypad pin GPIO: upper-row data, line directions, interrupt sense and polarity.
//
// Contract
// [R01] 16-bit data register at 0xC4 serves only Y lines 11 to 8.
// [R02] Output Y-high pin drives written data bit ANDed with its mask bit.
// [R03] Reading an input Y-high pin returns its level ANDed with its mask.
// [R04] Bits 11..8 are per-pin enables for Y lines 11..8, reset zero.
// [R05] Bits 3..0 hold pin data for Y lines 11..8, reset zero.
// [R06] X line direction register at 0xC6, one means output, reset 0x00.
// [R07] Y low direction register at 0xC7, one means output, reset inputs.
// [R08] Y high direction register at 0xC8, low four bits, reset 0x08.
// [R09] X line interrupt type at 0xC9, zero edge, one level, reset zero.
// [R10] Y low interrupt type at 0xCA, zero edge, one level, reset zero.
// [R11] Polarity bit: zero low or falling, one high or rising; reset ones.
// [R12] Reserved data and direction bits ignore writes and read zero.
// [R13] Edge pins latch events on transitions; level pins signal while level persists.
`timescale 1ns/10ps
module keypad_gpio #(
   parameter int X_LINES = 8,
   parameter int Y_LOW_LINES = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   output logic [15:0] regRdData,
   output logic regRdValid,
   input wire logic [X_LINES-1:0] keyLineXIn,
   output logic [X_LINES-1:0] keyLineXOut,
   output logic [X_LINES-1:0] keyLineXOe,
   input wire logic [X_LINES-1:0] xLineDrive,
   input wire logic [Y_LOW_LINES-1:0] keyLineYLowIn,
   output logic [Y_LOW_LINES-1:0] keyLineYLowOut,
   output logic [Y_LOW_LINES-1:0] keyLineYLowOe,
   input wire logic [Y_LOW_LINES-1:0] yLowDrive,
   input wire logic [3:0] keyLineYHighIn,
   output logic [3:0] keyLineYHighOut,
   output logic [3:0] keyLineYHighOe,
   input wire logic [X_LINES-1:0] xEventClear,
   input wire logic [Y_LOW_LINES-1:0] yLowEventClear,
   output logic [X_LINES-1:0] xEvent,
   output logic [Y_LOW_LINES-1:0] yLowEvent
);
   ////////////////////////////////////////////////////////////////////////////////
   // Register state.
   logic [15:0] pinDataUpperRows;
   logic [X_LINES-1:0] directionXLines;
   logic [Y_LOW_LINES-1:0] directionYLowLines;
   logic [3:0] directionYHighLines;
   logic [X_LINES-1:0] irqTypeXLines;
   logic [Y_LOW_LINES-1:0] irqTypeYLowLines;
   logic [X_LINES-1:0] polarityXLines;
   logic [Y_LOW_LINES-1:0] polarityYLowLines;
   logic [15:0] next_pinDataUpperRows;
   logic [X_LINES-1:0] next_directionXLines;
   logic [Y_LOW_LINES-1:0] next_directionYLowLines;
   logic [3:0] next_directionYHighLines;
   logic [X_LINES-1:0] next_irqTypeXLines;
   logic [Y_LOW_LINES-1:0] next_irqTypeYLowLines;
   logic [X_LINES-1:0] next_polarityXLines;
   logic [Y_LOW_LINES-1:0] next_polarityYLowLines;
   logic [15:0] next_regRdData;
   logic next_regRdValid;
   logic [3:0] yHighData;
   logic [3:0] yHighEnable;
   logic [3:0] yHighReadback;

   assign yHighData = pinDataUpperRows[keypad_gpio_pkg::PIN_VALUE_LSB +: 4];
   assign yHighEnable = pinDataUpperRows[keypad_gpio_pkg::PIN_ENABLE_LSB +: 4];

   // Readback per Y-high pin: inputs show the gated pin, outputs the gated stored bit.
   // [R03] masked input read
   always_comb begin
      for (int i = 0; i < keypad_gpio_pkg::Y_HIGH_COUNT; i++) begin
         yHighReadback[i] = yHighEnable[i]
            & (directionYHighLines[i] ? yHighData[i] : keyLineYHighIn[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes and reads; only listed offsets respond, others read zero.
   always_comb begin
      next_pinDataUpperRows = pinDataUpperRows;
      next_directionXLines = directionXLines;
      next_directionYLowLines = directionYLowLines;
      next_directionYHighLines = directionYHighLines;
      next_irqTypeXLines = irqTypeXLines;
      next_irqTypeYLowLines = irqTypeYLowLines;
      next_polarityXLines = polarityXLines;
      next_polarityYLowLines = polarityYLowLines;
      next_regRdData = regRdData;
      next_regRdValid = regRead;
      if (regWrite) begin
         unique case (regAddr)
            // [R01] data register write
            keypad_gpio_pkg::OFS_PIN_DATA_UPPER_ROWS: begin
               // [R12] reserved bits dropped
               next_pinDataUpperRows = regWrData & keypad_gpio_pkg::DATA_WRITABLE_MASK;
            end
            // [R06] X direction write
            keypad_gpio_pkg::OFS_DIRECTION_X_LINES: begin
               next_directionXLines = regWrData[X_LINES-1:0];
            end
            // [R07] Y low direction
            keypad_gpio_pkg::OFS_DIRECTION_Y_LOW_LINES: begin
               next_directionYLowLines = regWrData[Y_LOW_LINES-1:0];
            end
            // [R08] Y high direction
            keypad_gpio_pkg::OFS_DIRECTION_Y_HIGH_LINES: begin
               next_directionYHighLines = regWrData[3:0];
            end
            // [R09] X sense type
            keypad_gpio_pkg::OFS_IRQ_TYPE_X_LINES: begin
               next_irqTypeXLines = regWrData[X_LINES-1:0];
            end
            // [R10] Y low sense type
            keypad_gpio_pkg::OFS_IRQ_TYPE_Y_LOW_LINES: begin
               next_irqTypeYLowLines = regWrData[Y_LOW_LINES-1:0];
            end
            // [R11] polarity select
            keypad_gpio_pkg::OFS_POLARITY_X_LINES: begin
               next_polarityXLines = regWrData[X_LINES-1:0];
            end
            keypad_gpio_pkg::OFS_POLARITY_Y_LOW_LINES: begin
               next_polarityYLowLines = regWrData[Y_LOW_LINES-1:0];
            end
            default: begin
            end
         endcase
      end
      if (regRead) begin
         next_regRdData = 16'h0000;
         unique case (regAddr)
            // [R04] enables read back, data bits gated
            keypad_gpio_pkg::OFS_PIN_DATA_UPPER_ROWS: begin
               next_regRdData = {4'h0, yHighEnable, 4'h0, yHighReadback};
            end
            keypad_gpio_pkg::OFS_DIRECTION_X_LINES: begin
               next_regRdData[X_LINES-1:0] = directionXLines;
            end
            keypad_gpio_pkg::OFS_DIRECTION_Y_LOW_LINES: begin
               next_regRdData[Y_LOW_LINES-1:0] = directionYLowLines;
            end
            // [R12] upper bits zero
            keypad_gpio_pkg::OFS_DIRECTION_Y_HIGH_LINES: begin
               next_regRdData[3:0] = directionYHighLines;
            end
            keypad_gpio_pkg::OFS_IRQ_TYPE_X_LINES: begin
               next_regRdData[X_LINES-1:0] = irqTypeXLines;
            end
            keypad_gpio_pkg::OFS_IRQ_TYPE_Y_LOW_LINES: begin
               next_regRdData[Y_LOW_LINES-1:0] = irqTypeYLowLines;
            end
            keypad_gpio_pkg::OFS_POLARITY_X_LINES: begin
               next_regRdData[X_LINES-1:0] = polarityXLines;
            end
            keypad_gpio_pkg::OFS_POLARITY_Y_LOW_LINES: begin
               next_regRdData[Y_LOW_LINES-1:0] = polarityYLowLines;
            end
            default: begin
            end
         endcase
      end
   end

   // Register bank; the clock enable freezes every bit.
   // [R04] [R05] reset values
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinDataUpperRows <= keypad_gpio_pkg::RST_PIN_DATA_UPPER_ROWS;
         directionXLines <= keypad_gpio_pkg::RST_DIRECTION_X_LINES;
         directionYLowLines <= keypad_gpio_pkg::RST_DIRECTION_Y_LOW_LINES;
         directionYHighLines <= keypad_gpio_pkg::RST_DIRECTION_Y_HIGH_LINES;
         irqTypeXLines <= keypad_gpio_pkg::RST_IRQ_TYPE;
         irqTypeYLowLines <= keypad_gpio_pkg::RST_IRQ_TYPE;
         polarityXLines <= keypad_gpio_pkg::RST_POLARITY;
         polarityYLowLines <= keypad_gpio_pkg::RST_POLARITY;
         regRdData <= 16'h0000;
         regRdValid <= 1'b0;
      end else if (ce) begin
         pinDataUpperRows <= next_pinDataUpperRows;
         directionXLines <= next_directionXLines;
         directionYLowLines <= next_directionYLowLines;
         directionYHighLines <= next_directionYHighLines;
         irqTypeXLines <= next_irqTypeXLines;
         irqTypeYLowLines <= next_irqTypeYLowLines;
         polarityXLines <= next_polarityXLines;
         polarityYLowLines <= next_polarityYLowLines;
         regRdData <= next_regRdData;
         regRdValid <= next_regRdValid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers are registered so the pads never see decode glitches; one cycle late.
   // [R02] masked output drive
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         keyLineXOut <= '0;
         keyLineXOe <= '0;
         keyLineYLowOut <= '0;
         keyLineYLowOe <= '0;
         keyLineYHighOut <= 4'h0;
         keyLineYHighOe <= 4'h0;
      end else if (ce) begin
         keyLineXOut <= xLineDrive;
         keyLineXOe <= directionXLines;
         keyLineYLowOut <= yLowDrive;
         keyLineYLowOe <= directionYLowLines;
         keyLineYHighOut <= yHighData & yHighEnable;
         keyLineYHighOe <= directionYHighLines;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event sensing for X lines and Y lines 7 to 0.
   // [R13] X line events
   pin_event_detect #(
      .WIDTH(X_LINES)
   ) xDetect (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .pinIn(keyLineXIn),
      .levelType(irqTypeXLines),
      .polarity(polarityXLines),
      .eventClear(xEventClear),
      .eventFlag(xEvent)
   );

   // [R13] Y low events
   pin_event_detect #(
      .WIDTH(Y_LOW_LINES)
   ) yLowDetect (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .pinIn(keyLineYLowIn),
      .levelType(irqTypeYLowLines),
      .polarity(polarityYLowLines),
      .eventClear(yLowEventClear),
      .eventFlag(yLowEvent)
   );
endmodule

// ---- keypad_gpio_pkg.sv ----
// Package with register offsets, field layouts and reset values for the keypad GPIO block.
package keypad_gpio_pkg;
   localparam logic [7:0] OFS_PIN_DATA_UPPER_ROWS = 8'hC4;
   localparam logic [7:0] OFS_DIRECTION_X_LINES = 8'hC6;
   localparam logic [7:0] OFS_DIRECTION_Y_LOW_LINES = 8'hC7;
   localparam logic [7:0] OFS_DIRECTION_Y_HIGH_LINES = 8'hC8;
   localparam logic [7:0] OFS_IRQ_TYPE_X_LINES = 8'hC9;
   localparam logic [7:0] OFS_IRQ_TYPE_Y_LOW_LINES = 8'hCA;
   localparam logic [7:0] OFS_POLARITY_X_LINES = 8'hCF;
   localparam logic [7:0] OFS_POLARITY_Y_LOW_LINES = 8'hD0;
   // Field positions inside the upper-row data register.
   localparam int PIN_VALUE_LSB = 0;
   localparam int PIN_ENABLE_LSB = 8;
   localparam int Y_HIGH_COUNT = 4;
   localparam int LINE_COUNT = 8;
   // Reset values.
   localparam logic [15:0] RST_PIN_DATA_UPPER_ROWS = 16'h0000;
   localparam logic [7:0] RST_DIRECTION_X_LINES = 8'h00;
   localparam logic [7:0] RST_DIRECTION_Y_LOW_LINES = 8'h00;
   localparam logic [3:0] RST_DIRECTION_Y_HIGH_LINES = 4'h8;
   localparam logic [7:0] RST_IRQ_TYPE = 8'h00;
   localparam logic [7:0] RST_POLARITY = 8'hFF;
   // Bits of the data register that exist; the rest are reserved.
   localparam logic [15:0] DATA_WRITABLE_MASK = 16'h0F0F;
endpackage

// ---- pin_event_detect.sv ----
// Per-pin edge or level event detector for the keypad lines.
`timescale 1ns/10ps
module pin_event_detect #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [WIDTH-1:0] pinIn,
   input wire logic [WIDTH-1:0] levelType,
   input wire logic [WIDTH-1:0] polarity,
   input wire logic [WIDTH-1:0] eventClear,
   output logic [WIDTH-1:0] eventFlag
);
   logic [WIDTH-1:0] sampleNow;
   logic [WIDTH-1:0] samplePrev;
   logic primed;
   logic [WIDTH-1:0] next_eventFlag;
   logic [WIDTH-1:0] rising;
   logic [WIDTH-1:0] falling;
   logic [WIDTH-1:0] edgeHit;
   logic [WIDTH-1:0] levelHit;

   // Edges are trusted from the first real sample on; that sample is compared with the reset zero in samplePrev.
   // [R13] edge latch or level
   always_comb begin
      rising = sampleNow & ~samplePrev;
      falling = ~sampleNow & samplePrev;
      edgeHit = primed ? ((polarity & rising) | (~polarity & falling)) : '0;
      levelHit = ~(sampleNow ^ polarity);
      // A new edge wins over a clear arriving in the same cycle.
      next_eventFlag = (levelType & levelHit)
         | (~levelType & ((eventFlag & ~eventClear) | edgeHit));
   end

   // Sample pins and hold flags; the clock enable freezes everything.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sampleNow <= '0;
         samplePrev <= '0;
         primed <= 1'b0;
         eventFlag <= '0;
      end else if (ce) begin
         sampleNow <= pinIn;
         samplePrev <= sampleNow;
         primed <= 1'b1;
         eventFlag <= next_eventFlag;
      end
   end
endmodule

// ---- keypad_gpio_monitor.sv ----
// Checker for the keypad GPIO register bus and pin direction outputs.
`timescale 1ns/10ps
module keypad_gpio_monitor #(
   parameter int X_LINES = 8,
   parameter int Y_LOW_LINES = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic [15:0] regRdData,
   input wire logic regRdValid,
   input wire logic [X_LINES-1:0] keyLineXOe,
   input wire logic [Y_LOW_LINES-1:0] keyLineYLowOe,
   input wire logic [3:0] keyLineYHighOut,
   input wire logic [3:0] keyLineYHighOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // A single write to one offset; a second write at once would overwrite what is being checked.
   sequence wrOnce(logic [7:0] a);
      ce && regWrite && regAddr == a ##1 !(regWrite && regAddr == a);
   endsequence
   //////////////////////////////////////////////////
   chk_read_answer: assert property (ce && regRead |=> regRdValid)
      else $error("read strobe got no answer");
   chk_answer_cause: assert property ($rose(regRdValid) |-> $past(regRead && ce))
      else $error("read answer without a read strobe");
   chk_data_hold: assert property (!$past(regRead) |-> $stable(regRdData))
      else $error("read data changed without a read");
   chk_unmapped_zero: assert property (ce && regRead && regAddr == 8'hC5 |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   chk_y_high_drive: assert property (wrOnce(8'hC4) |-> ##1 keyLineYHighOut == ($past(regWrData[3:0], 2) & $past(regWrData[11:8], 2)))
      else $error("upper row pin drive not data and enable");
   chk_x_dir: assert property (wrOnce(8'hC6) |-> ##1 keyLineXOe == $past(regWrData[X_LINES-1:0], 2))
      else $error("x line enables do not follow register");
   chk_y_low_dir: assert property (wrOnce(8'hC7) |-> ##1 keyLineYLowOe == $past(regWrData[Y_LOW_LINES-1:0], 2))
      else $error("y low enables do not follow register");
   chk_y_high_dir: assert property (wrOnce(8'hC8) |-> ##1 keyLineYHighOe == $past(regWrData[3:0], 2))
      else $error("y high enables do not follow register");
   chk_reset_dir: assert property ($rose(reset_n) |=> keyLineYHighOe == 4'h8)
      else $error("y high direction reset value wrong");
   // Main scenarios that the bench should reach.
   cover property (ce && regRead && regAddr == 8'hC4);
   cover property (wrOnce(8'hC4));
   cover property (wrOnce(8'hC8));
endmodule
bind keypad_gpio keypad_gpio_monitor #(.X_LINES(X_LINES), .Y_LOW_LINES(Y_LOW_LINES)) keypad_gpio_monitor_i (
   .clk(clk), .reset_n(reset_n), .ce(ce), .regWrite(regWrite), .regRead(regRead),
   .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
   .keyLineXOe(keyLineXOe), .keyLineYLowOe(keyLineYLowOe), .keyLineYHighOut(keyLineYHighOut),
   .keyLineYHighOe(keyLineYHighOe));

// ---- keypad_pins_model.sv ----
// Outside circuitry on the keypad pins: resolves each pin from device drive and outside level.
`timescale 1ns/10ps
module keypad_pins_model (
   input wire logic [7:0] xOut,
   input wire logic [7:0] xOe,
   input wire logic [7:0] xExt,
   output logic [7:0] xIn,
   input wire logic [7:0] yOut,
   input wire logic [7:0] yOe,
   input wire logic [7:0] yExt,
   output logic [7:0] yIn,
   input wire logic [3:0] hOut,
   input wire logic [3:0] hOe,
   input wire logic [3:0] hExt,
   output logic [3:0] hIn
);
   // A driven pin shows the device level; an undriven one shows the outside level.
   assign xIn = (xOe & xOut) | (~xOe & xExt);
   assign yIn = (yOe & yOut) | (~yOe & yExt);
   assign hIn = (hOe & hOut) | (~hOe & hExt);
endmodule

// ---- tb_keypad_pin_gpio_direction_sense.sv ----
// Testbench for the keypad GPIO registers, pin drive and event sensing.
`timescale 1ns/10ps
module tb_keypad_pin_gpio_direction_sense;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic [15:0] regRdData;
   logic regRdValid;
   logic [7:0] xIn, xOut, xOe, xEvent, yIn, yOut, yOe, yEvent;
   logic [7:0] xExt = 8'h00, yExt = 8'h00, xClr = 8'h00, yClr = 8'h00;
   logic [7:0] xDrive = 8'h3C, yDrive = 8'hC3;
   logic [3:0] hIn, hOut, hOe, hExt = 4'h0;
   logic [7:0] addrs [9] = '{8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCF, 8'hD0};
   logic [15:0] rstVal [9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h8, 16'h0, 16'h0, 16'hFF, 16'hFF};
   logic [15:0] pats [2] = '{16'hFFFF, 16'hA5A5};
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   // Free-running clock, 100 ns period.
   initial begin
      forever #50 clk = ~clk;
   end
   keypad_gpio keypad_gpio_i (.clk(clk), .reset_n(reset_n), .ce(1'b1), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .keyLineXIn(xIn), .keyLineXOut(xOut), .keyLineXOe(xOe),
      .xLineDrive(xDrive), .keyLineYLowIn(yIn), .keyLineYLowOut(yOut), .keyLineYLowOe(yOe),
      .yLowDrive(yDrive), .keyLineYHighIn(hIn), .keyLineYHighOut(hOut), .keyLineYHighOe(hOe),
      .xEventClear(xClr), .yLowEventClear(yClr), .xEvent(xEvent), .yLowEvent(yEvent));
   keypad_pins_model keypad_pins_model_i (.xOut(xOut), .xOe(xOe), .xExt(xExt), .xIn(xIn),
      .yOut(yOut), .yOe(yOe), .yExt(yExt), .yIn(yIn), .hOut(hOut), .hOe(hOe), .hExt(hExt),
      .hIn(hIn));
   //////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Strobes are raised after a falling edge and held across exactly one rising edge.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   // The answer is valid for one cycle right after the taking edge, so it is read then.
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRead = 1'b0;
      check(what, regRdValid === 1'b1 ? regRdData : 16'hXXXX, exp);
   endtask
   task automatic clearAll();
      xClr = 8'hFF;
      yClr = 8'hFF;
      @(negedge clk);
      xClr = 8'h00;
      yClr = 8'h00;
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Cuts a hang short; the whole sequence needs under two hundred cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         print_verdict();
      end
   end
   //////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      repeat (2) @(negedge clk);
      check("y high oe", {12'h0, hOe}, 16'h0008);
      check("events", {xEvent, yEvent}, 16'h0000);
      foreach (addrs[i]) rd(addrs[i], rstVal[i], "reset value");
      foreach (pats[p]) begin
         for (int i = 1; i < 9; i++) wr(addrs[i], pats[p]);
         for (int i = 1; i < 9; i++) rd(addrs[i], addrs[i] == 8'hC5 ? 16'h0 :
            pats[p] & (addrs[i] == 8'hC8 ? 16'h000F : 16'h00FF), "readback");
      end
      check("oe", {xOe, yOe}, 16'hA5A5);
      check("y high oe", {12'h0, hOe}, 16'h0005);
      check("x out", {8'h0, xOut}, {8'h0, xDrive});
      wr(8'hC8, 16'h000F);
      wr(8'hC4, 16'hF6FA);
      rd(8'hC4, 16'h0602, "data out");
      check("y high out", {12'h0, hOut}, 16'h0002);
      wr(8'hC8, 16'h0000);
      hExt = 4'hD;
      rd(8'hC4, 16'h0604, "data in");
      wr(8'hC6, 16'h0000);
      wr(8'hC7, 16'h0000);
      wr(8'hC9, 16'h0000);
      wr(8'hCA, 16'h0000);
      wr(8'hCF, 16'h00FF);
      xExt = 8'h00;
      yExt = 8'h00;
      repeat (4) @(negedge clk);
      clearAll();
      xExt = 8'h01;
      repeat (4) @(negedge clk);
      xExt = 8'h00;
      repeat (4) @(negedge clk);
      check("edge latched", {8'h0, xEvent}, 16'h0001);
      clearAll();
      repeat (2) @(negedge clk);
      check("edge cleared", {8'h0, xEvent}, 16'h0000);
      wr(8'hC9, 16'h0002);
      xExt = 8'h02;
      repeat (4) @(negedge clk);
      check("level on", {8'h0, xEvent}, 16'h0002);
      xExt = 8'h00;
      repeat (4) @(negedge clk);
      check("level off", {8'h0, xEvent}, 16'h0000);
      wr(8'hC9, 16'h0000);
      wr(8'hCF, 16'h00FE);
      clearAll();
      xExt = 8'h01;
      repeat (4) @(negedge clk);
      check("no rise event", {8'h0, xEvent}, 16'h0000);
      xExt = 8'h00;
      repeat (4) @(negedge clk);
      check("fall event", {8'h0, xEvent}, 16'h0001);
      wr(8'hCA, 16'h00FF);
      wr(8'hD0, 16'h0000);
      repeat (4) @(negedge clk);
      check("y low level", {8'h0, yEvent}, 16'h00FF);
      yExt = 8'hFF;
      repeat (4) @(negedge clk);
      check("y low level off", {8'h0, yEvent}, 16'h0000);
      print_verdict();
   end
endmodule
